/* hdl/sfp_param_read.sv */
// Parameter-table read logic of a serial flash with a Wishbone slave port.
// Assumes serial pins are asynchronous and toggle slowly against i_clk,
// and that i_write_busy comes from the flash write logic on i_clk.

module sfp_param_read
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_spi_sclk,
    input wire logic i_spi_cs_n,
    input wire logic i_serial_in_pin,
    output logic o_spi_so,
    output logic o_spi_so_oe,
    input wire logic i_write_busy,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [sfp_pkg::WB_AW-1:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    import sfp_pkg::*;

    sfp_pins_type pins_in;
    sfp_pins_type sync1_reg;
    sfp_pins_type sync2_reg;
    sfp_pins_type hist_reg;
    sfp_state_type state_reg;
    logic [4:0] cnt_reg;
    logic [7:0] opc_reg;
    logic [23:0] addr_reg;
    logic [7:0] out_shift_reg;
    logic so_reg;
    logic ctrl_en_reg;
    logic reject_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_high;
    logic opc_done;
    logic [7:0] opc_full;
    logic opc_ok;
    logic opc_refused_busy;
    logic wb_req;
    logic wb_write;

    // Table lookup; unlisted locations read as erased space.
    function automatic logic [7:0] table_byte(input logic [23:0] a);
        logic [7:0] d;
        d = TBL_FILL;
        case (a)
            24'h00_0000: d = TBL_SIG0;
            24'h00_0001: d = TBL_SIG1;
            24'h00_0002: d = TBL_SIG2;
            24'h00_0003: d = TBL_SIG3;
            24'h00_0004: d = TBL_MINOR;
            24'h00_0005: d = TBL_MAJOR;
            24'h00_0006: d = TBL_HDR_CNT;
            24'h00_0008: d = TBL_PARAM_ID;
            24'h00_0009: d = TBL_MINOR;
            24'h00_000A: d = TBL_MAJOR;
            24'h00_000B: d = TBL_PT_LEN;
            24'h00_000C: d = TBL_PTR0;
            24'h00_000D: d = TBL_PTR1;
            24'h00_000E: d = TBL_PTR2;
            24'h00_0030: d = TBL_ERASE_CAPS;
            24'h00_0031: d = TBL_ERASE_OPC;
            24'h00_0032: d = TBL_READ_CAPS;
            24'h00_0034: d = TBL_DENS0;
            24'h00_0035: d = TBL_DENS1;
            24'h00_0036: d = TBL_DENS2;
            24'h00_0037: d = TBL_DENS3;
            24'h00_0038: d = TBL_QREAD_WAIT;
            24'h00_0039: d = TBL_QREAD_OPC;
            default: d = TBL_FILL;
        endcase
        return d;
    endfunction

    // Two-stage synchroniser for the pins; only stage two feeds logic.
    assign pins_in = '{sclk: i_spi_sclk, cs_n: i_spi_cs_n,
                       sin: i_serial_in_pin};
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sync1_reg <= '{sclk: 1'b0, cs_n: 1'b1, sin: 1'b0};
            sync2_reg <= '{sclk: 1'b0, cs_n: 1'b1, sin: 1'b0};
            hist_reg <= '{sclk: 1'b0, cs_n: 1'b1, sin: 1'b0};
        end
        else
        begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            hist_reg <= sync2_reg;
        end
    end

    // Edge detection on the second stage against its own history.
    assign sel_high = sync2_reg.cs_n;
    assign sclk_rise = sync2_reg.sclk & ~hist_reg.sclk & ~sel_high;
    assign sclk_fall = ~sync2_reg.sclk & hist_reg.sclk & ~sel_high;

    // Opcode decode on the eighth rising edge of the command byte.
    assign opc_done = (state_reg == SFP_OPCODE) && sclk_rise
                      && (cnt_reg == OPC_LAST);
    assign opc_full = {opc_reg[6:0], sync2_reg.sin};
    assign opc_ok = (opc_full == OPC_PARAM_READ) && ctrl_en_reg
                    && !i_write_busy;
    assign opc_refused_busy = opc_done && (opc_full == OPC_PARAM_READ)
                              && i_write_busy;

    // Command sequencer; select high always returns it to idle.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_reg <= SFP_IDLE;
            cnt_reg <= CNT_RESET;
        end
        else if (sel_high)
        begin
            state_reg <= SFP_IDLE;
            cnt_reg <= CNT_RESET;
        end
        else
        begin
            case (state_reg)
                SFP_IDLE:
                begin
                    state_reg <= SFP_OPCODE;
                    cnt_reg <= CNT_RESET;
                end
                SFP_OPCODE:
                begin
                    if (sclk_rise)
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == OPC_LAST)
                        begin
                            cnt_reg <= CNT_RESET;
                            // A refused command only waits for deselect.
                            state_reg <= opc_ok ? SFP_ADDR
                                                : SFP_IGNORE;
                        end
                    end
                end
                SFP_ADDR:
                begin
                    if (sclk_rise)
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == ADDR_LAST)
                        begin
                            cnt_reg <= CNT_RESET;
                            state_reg <= SFP_DUMMY;
                        end
                    end
                end
                SFP_DUMMY:
                begin
                    if (sclk_rise)
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == DUMMY_LAST)
                        begin
                            cnt_reg <= CNT_RESET;
                            state_reg <= SFP_DATA;
                        end
                    end
                end
                SFP_DATA:
                begin
                    if (sclk_fall)
                    begin
                        cnt_reg <= (cnt_reg == DATA_LAST) ? CNT_RESET
                                   : cnt_reg + 5'h01;
                    end
                end
                SFP_IGNORE:
                begin
                    state_reg <= SFP_IGNORE;
                end
                default:
                begin
                    state_reg <= SFP_IDLE;
                    cnt_reg <= CNT_RESET;
                end
            endcase
        end
    end

    // Opcode shift register, cleared at each new selection.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            opc_reg <= 8'h00;
        else if (state_reg == SFP_IDLE)
            opc_reg <= 8'h00;
        else if ((state_reg == SFP_OPCODE) && sclk_rise)
            opc_reg <= opc_full;
    end

    // Table address: shifted in MSB first, then advanced per output byte.
    // The 24-bit counter wraps to zero on its own after its top value.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            addr_reg <= ADDR_RESET;
        else if ((state_reg == SFP_ADDR) && sclk_rise)
            addr_reg <= {addr_reg[22:0], sync2_reg.sin};
        else if ((state_reg == SFP_DATA) && sclk_fall
                 && (cnt_reg == DATA_LAST))
            addr_reg <= addr_reg + 24'h00_0001;
    end

    // Output shifter: loaded at the last dummy edge, bits leave on falls.
    // Loading early keeps the first bit ready for the very first fall.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            out_shift_reg <= 8'h00;
            so_reg <= 1'b0;
        end
        else if ((state_reg == SFP_DUMMY) && sclk_rise
                 && (cnt_reg == DUMMY_LAST) && !sel_high)
        begin
            out_shift_reg <= table_byte(addr_reg);
        end
        else if ((state_reg == SFP_DATA) && sclk_fall)
        begin
            so_reg <= out_shift_reg[7];
            if (cnt_reg == DATA_LAST)
                out_shift_reg <= table_byte(addr_reg + 24'h00_0001);
            else
                out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
    end

    // The pin is driven only while data is streaming.
    assign o_spi_so = so_reg;
    assign o_spi_so_oe = (state_reg == SFP_DATA);

    // Wishbone classic slave: ack one cycle after a request, data with it.
    assign wb_req = i_wb_cyc && i_wb_stb;
    assign wb_write = wb_req && i_wb_we && ack_reg && i_wb_sel[0];
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= wb_req && !ack_reg;
            rdat_reg <= 32'h0000_0000;
            if (wb_req && !ack_reg && !i_wb_we)
            begin
                case (i_wb_adr)
                    ADR_CTRL: rdat_reg[CTRL_EN_BIT] <= ctrl_en_reg;
                    ADR_STATUS:
                    begin
                        rdat_reg[STAT_ACTIVE_BIT] <= o_spi_so_oe;
                        rdat_reg[STAT_REJECT_BIT] <= reject_reg;
                        rdat_reg[STAT_BUSY_BIT] <= i_write_busy;
                    end
                    ADR_ADDR: rdat_reg[23:0] <= addr_reg;
                    default: rdat_reg <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    // Control enable; when clear the read opcode is still decoded but refused.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            ctrl_en_reg <= CTRL_EN_RESET;
        else if (wb_write && (i_wb_adr == ADR_CTRL))
            ctrl_en_reg <= i_wb_dat[CTRL_EN_BIT];
    end

    // Sticky flag for refusals while busy, write one to clear; a new busy refusal wins.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            reject_reg <= 1'b0;
        else if (opc_refused_busy)
            reject_reg <= 1'b1;
        else if (wb_write && (i_wb_adr == ADR_STATUS)
                 && i_wb_dat[STAT_REJECT_BIT])
            reject_reg <= 1'b0;
    end

    // Checks on the serial sequencer and the table contents.
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    a_opcode_accept: assert property (
        opc_done && opc_full == OPC_PARAM_READ && ctrl_en_reg
        && !i_write_busy && !sel_high |=> state_reg == SFP_ADDR)
        else $error("Read opcode was not accepted.");

    a_addr_length: assert property (
        state_reg == SFP_ADDR && sclk_rise && cnt_reg == ADDR_LAST
        && !sel_high |=> state_reg == SFP_DUMMY && cnt_reg == CNT_RESET)
        else $error("Address phase length is wrong.");

    a_out_on_fall: assert property (
        so_reg != $past(so_reg) |-> $past(sclk_fall)
        && $past(state_reg) == SFP_DATA)
        else $error("Output bit changed without a falling edge.");

    a_addr_step: assert property (
        state_reg == SFP_DATA && sclk_fall && cnt_reg == DATA_LAST
        && !sel_high |=> addr_reg == $past(addr_reg) + 24'h00_0001)
        else $error("Address did not advance after a byte.");

    a_addr_wrap: assert property (
        state_reg == SFP_DATA && sclk_fall && cnt_reg == DATA_LAST
        && addr_reg == ADDR_TOP |=> addr_reg == ADDR_RESET)
        else $error("Address did not wrap to zero.");

    a_select_release: assert property (
        sel_high |=> !o_spi_so_oe && state_reg == SFP_IDLE)
        else $error("Output still driven after deselect.");

    a_busy_refuse: assert property (
        opc_refused_busy && !sel_high |=> state_reg == SFP_IGNORE
        ##1 reject_reg)
        else $error("Busy did not refuse the command.");

    a_first_byte: assert property (
        state_reg == SFP_DUMMY && sclk_rise && cnt_reg == DUMMY_LAST
        && addr_reg == ADDR_RESET && !sel_high
        |=> out_shift_reg == 8'h53)
        else $error("Signature byte zero is wrong.");

    a_table_values: assert property (
        table_byte(24'h00_0005) == 8'h01 && table_byte(24'h00_0007) == 8'hFF
        && table_byte(24'h00_000B) == 8'h09
        && table_byte(24'h00_000C) == 8'h30)
        else $error("Header table value is wrong.");

    a_basic_table: assert property (
        table_byte(24'h00_0030) == 8'hED && table_byte(24'h00_0031) == 8'h20
        && table_byte(24'h00_0032) == 8'hF1
        && table_byte(24'h00_0037) == 8'h03
        && table_byte(24'h00_0039) == 8'hEB
        && table_byte(24'h00_0040) == 8'hFF)
        else $error("Basic parameter table value is wrong.");

    c_read_started: cover property (opc_done && opc_ok && !sel_high);
    c_byte_streamed: cover property (
        state_reg == SFP_DATA && sclk_fall && cnt_reg == DATA_LAST);
    c_busy_refused: cover property (opc_refused_busy);
    c_abort_in_data: cover property (state_reg == SFP_DATA && sel_high);
endmodule

/* hdl/sfp_pkg.sv */
// Shared constants and types for the parameter-table read block.
// Assumes one system clock; serial pins arrive from another clock domain.
package sfp_pkg;

    // Command opcode that starts a parameter-table read.
    localparam logic [7:0] OPC_PARAM_READ = 8'h5A;

    // Last bit index of each serial phase, counted from zero.
    localparam logic [4:0] OPC_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST = 5'h17;
    localparam logic [4:0] DUMMY_LAST = 5'h07;
    localparam logic [4:0] DATA_LAST = 5'h07;
    localparam logic [4:0] CNT_RESET = 5'h00;

    // Table address after reset and at its highest location.
    localparam logic [23:0] ADDR_RESET = 24'h00_0000;
    localparam logic [23:0] ADDR_TOP = 24'hFF_FFFF;

    // Register bus layout, byte addresses of aligned 32-bit words.
    localparam int WB_AW = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_ADDR = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam int STAT_ACTIVE_BIT = 0;
    localparam int STAT_REJECT_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam logic CTRL_EN_RESET = 1'b1;

    // Parameter-table contents at defined locations.
    localparam logic [7:0] TBL_SIG0 = 8'h53;
    localparam logic [7:0] TBL_SIG1 = 8'h46;
    localparam logic [7:0] TBL_SIG2 = 8'h44;
    localparam logic [7:0] TBL_SIG3 = 8'h50;
    localparam logic [7:0] TBL_MINOR = 8'h00;
    localparam logic [7:0] TBL_MAJOR = 8'h01;
    localparam logic [7:0] TBL_HDR_CNT = 8'h00;
    localparam logic [7:0] TBL_PARAM_ID = 8'h00;
    localparam logic [7:0] TBL_PT_LEN = 8'h09;
    localparam logic [7:0] TBL_PTR0 = 8'h30;
    localparam logic [7:0] TBL_PTR1 = 8'h00;
    localparam logic [7:0] TBL_PTR2 = 8'h00;
    localparam logic [7:0] TBL_ERASE_CAPS = 8'hED;
    localparam logic [7:0] TBL_ERASE_OPC = 8'h20;
    localparam logic [7:0] TBL_READ_CAPS = 8'hF1;
    localparam logic [7:0] TBL_DENS0 = 8'hFF;
    localparam logic [7:0] TBL_DENS1 = 8'hFF;
    localparam logic [7:0] TBL_DENS2 = 8'hFF;
    localparam logic [7:0] TBL_DENS3 = 8'h03;
    localparam logic [7:0] TBL_QREAD_WAIT = 8'h44;
    localparam logic [7:0] TBL_QREAD_OPC = 8'hEB;
    localparam logic [7:0] TBL_FILL = 8'hFF;

    // Serial command sequencer, Gray coded along the normal path.
    typedef enum logic [2:0]
    {
        SFP_IDLE = 3'b000,
        SFP_OPCODE = 3'b001,
        SFP_ADDR = 3'b011,
        SFP_DUMMY = 3'b010,
        SFP_DATA = 3'b110,
        SFP_IGNORE = 3'b111
    } sfp_state_type;

    // The three serial pins, moved together through the synchroniser.
    typedef struct packed
    {
        logic sclk;
        logic cs_n;
        logic sin;
    } sfp_pins_type;

endpackage

/* sim/sfp_host_model.sv */
// Host serial controller model that drives the block's serial pins.
// Assumes it shares i_clk with the block and runs serial mode 0.
module sfp_host_model
(
    input wire logic i_clk,
    input wire logic i_so,
    input wire logic i_so_oe,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sin
);
    logic [7:0] rx_q[$];
    logic oe_seen;

    // The serial clock idles low and stands still between frames.
    initial
    begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_sin = 1'b0;
        oe_seen = 1'b0;
    end

    // Half of the 800 ns serial period.
    task automatic half_bit();
        repeat (4) @(posedge i_clk);
    endtask

    // Sends the header, then clocks whole bytes and loose bits. Bits are
    // taken just before the next fall, well past the output latency.
    task automatic frame(input logic [7:0] opc, input logic [23:0] adr,
                         input int nbytes, input int extra);
        logic [39:0] cmd;
        logic [7:0] b;
        cmd = {opc, adr, 8'h00};
        b = 8'h00;
        rx_q.delete();
        oe_seen = 1'b0;
        @(posedge i_clk);
        o_cs_n <= 1'b0;
        half_bit();
        for (int i = 39; i >= 0; i--)
        begin
            o_sclk <= 1'b0;
            o_sin <= cmd[i];
            half_bit();
            o_sclk <= 1'b1;
            half_bit();
        end
        for (int i = 0; i < nbytes * 8 + extra; i++)
        begin
            o_sclk <= 1'b0;
            o_sin <= ~o_sin; // The line carries nothing now, so it wobbles.
            half_bit();
            o_sclk <= 1'b1;
            half_bit();
            // A released line floats up to one, so only driven bits count.
            b = {b[6:0], i_so_oe ? i_so : 1'b1};
            oe_seen = oe_seen | i_so_oe;
            if (i % 8 == 7)
                rx_q.push_back(b);
        end
        o_sclk <= 1'b0;
        half_bit();
        o_cs_n <= 1'b1;
        half_bit();
        half_bit();
    endtask
endmodule

/* sim/sfp_param_read_bench.sv */
// Self-checking bench for the parameter-table read block.
// Assumes the block and the host model share the 10 MHz clock.
module sfp_param_read_bench;
    timeunit 1ns;
    timeprecision 1ns;

    // Header bytes 00h..0Fh, then basic table bytes 30h..39h.
    localparam logic [127:0] HDR =
        128'h5346_4450_0001_00FF_0000_0109_3000_00FF;
    localparam logic [79:0] BPT = 80'hED20_F1FF_FFFF_FF03_44EB;

    logic clk = 1'b0;
    logic rst, sclk, cs_n, sin, so, so_oe, busy;
    logic cyc, stb, we, ack;
    logic [sfp_pkg::WB_AW-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int miscompares, check_count;

    // Clock of 100 ns period.
    always #50 clk = ~clk;

    sfp_param_read DUT (.i_clk(clk), .i_rst(rst), .i_spi_sclk(sclk),
        .i_spi_cs_n(cs_n), .i_serial_in_pin(sin), .o_spi_so(so),
        .o_spi_so_oe(so_oe), .i_write_busy(busy), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
        .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack));

    sfp_host_model HOST (.i_clk(clk), .i_so(so), .i_so_oe(so_oe),
        .o_sclk(sclk), .o_cs_n(cs_n), .o_sin(sin));

    // Expected table content; undefined places read as erased.
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        if (a < 24'h00_0010)
            return HDR[(15 - a[3:0]) * 8 +: 8];
        if (a >= 24'h00_0030 && a <= 24'h00_0039)
            return BPT[(9 - a[3:0]) * 8 +: 8];
        return 8'hFF;
    endfunction

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic compare(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One classic cycle; waits for ack under a bound, then releases.
    task automatic wb_access(input logic wr, input logic [7:0] a,
                             input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= wr;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wb_check(input logic [7:0] a, input logic [31:0] e,
                            input string what);
        logic [31:0] q;
        wb_access(1'b0, a, 32'h0000_0000, q);
        compare(what, e, q);
    endtask

    task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_access(1'b1, a, d, q);
    endtask

    // Reads n bytes from address a and judges every one.
    task automatic read_frame(input logic [23:0] a, input int n);
        logic [31:0] e;
        logic [31:0] g;
        HOST.frame(8'h5A, a, n, 0);
        compare("oe seen", 32'h0000_0001, {31'h0, HOST.oe_seen});
        compare("byte count", n, HOST.rx_q.size());
        for (int i = 0; i < n; i++)
        begin
            // The address wraps in 24 bits, as the block's counter does.
            e = {24'h0, exp_byte(24'(a + i))};
            g = {24'h0, HOST.rx_q[i]};
            compare("table byte", e, g);
        end
    endtask

    // Status shows the streaming bit while data leaves the pin.
    task automatic status_mid_frame();
        repeat (400) @(posedge clk);
        wb_check(sfp_pkg::ADR_STATUS, 32'h0000_0001, "streaming");
    endtask

    task automatic test_regs();
        wb_check(sfp_pkg::ADR_CTRL, 32'h0000_0001, "control reset");
        wb_check(sfp_pkg::ADR_STATUS, 32'h0000_0000, "status reset");
        wb_write(8'hFC, 32'hFFFF_FFFF);
        wb_check(8'hFC, 32'h0000_0000, "unmapped read");
        $display("Test registers done");
    endtask

    task automatic test_abort();
        HOST.frame(8'h5A, 24'h00_0000, 1, 4);
        compare("first byte", 32'h0000_0053, {24'h0, HOST.rx_q[0]});
        compare("enable after deselect", 32'h0, {31'h0, so_oe});
        wb_check(sfp_pkg::ADR_ADDR, 32'h0000_0001, "abort address");
        $display("Test abort done");
    endtask

    task automatic test_table();
        read_frame(24'h00_0000, 16);
        read_frame(24'h00_0007, 2);
        fork
            read_frame(24'h00_0030, 12);
            status_mid_frame();
        join
        $display("Test table done");
    endtask

    task automatic test_wrap();
        read_frame(24'hFF_FFFE, 3);
        wb_check(sfp_pkg::ADR_ADDR, 32'h0000_0001, "wrap address");
        $display("Test wrap done");
    endtask

    // Wrong opcode, busy write cycle and disabled block give no output.
    task automatic test_refuse();
        HOST.frame(8'h03, 24'h00_0000, 1, 0);
        compare("foreign opcode", 32'h0, {31'h0, HOST.oe_seen});
        compare("other byte", 32'h0000_00FF, {24'h0, HOST.rx_q[0]});
        @(posedge clk);
        busy <= 1'b1;
        HOST.frame(8'h5A, 24'h00_0000, 1, 0);
        compare("busy refusal", 32'h0, {31'h0, HOST.oe_seen});
        compare("busy byte", 32'h0000_00FF, {24'h0, HOST.rx_q[0]});
        wb_check(sfp_pkg::ADR_STATUS, 32'h0000_0006, "busy status");
        busy <= 1'b0;
        wb_write(sfp_pkg::ADR_STATUS, 32'h0000_0002);
        wb_check(sfp_pkg::ADR_STATUS, 32'h0000_0000, "status cleared");
        wb_write(sfp_pkg::ADR_CTRL, 32'h0000_0000);
        HOST.frame(8'h5A, 24'h00_0000, 1, 0);
        compare("disabled", 32'h0, {31'h0, HOST.oe_seen});
        wb_write(sfp_pkg::ADR_CTRL, 32'h0000_0001);
        read_frame(24'h00_0004, 2);
        $display("Test refusal done");
    endtask

    // Reset for five cycles, then the scenarios in turn.
    initial
    begin
        rst = 1'b1;
        busy = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = 4'h0;
        wdat = 32'h0000_0000;
        miscompares = 0;
        check_count = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        test_regs();
        test_abort();
        test_table();
        test_wrap();
        test_refuse();
        print_verdict();
    end
endmodule
